// ### hdl/scdd_cfg.svh
`ifndef SCDD_CFG_SVH
`define SCDD_CFG_SVH

// Register offsets
`define SCDD_ADDR_SKEW      12'h10A
`define SCDD_ADDR_DLY_MODE  12'h110
`define SCDD_ADDR_SF_DLY    12'h111
`define SCDD_ADDR_FINE_DLY  12'h112
`define SCDD_ADDR_DET_CTL   12'h11A
`define SCDD_ADDR_LOCK_STS  12'h11B
`define SCDD_ADDR_DCS1_CTL  12'h11C

// Field positions
`define SCDD_POS_SKEW_MSB   1
`define SCDD_POS_SKEW_LSB   0
`define SCDD_NEG_SKEW_MSB   3
`define SCDD_NEG_SKEW_LSB   2
`define SCDD_MODE_MSB       2
`define SCDD_MODE_LSB       0
`define SCDD_THR_MSB        4
`define SCDD_THR_LSB        3
`define SCDD_LOCK_BIT       0
`define SCDD_DCS_PWR_BIT    0
`define SCDD_DCS_EN_BIT     1

// Reset values
`define SCDD_RST_SKEW       4'h0
`define SCDD_RST_DLY_MODE   3'h0
`define SCDD_RST_SF_DLY     8'h00
`define SCDD_RST_FINE_DLY   8'hC0
`define SCDD_RST_DET_CTL    8'h09
`define SCDD_RST_DCS1_CTL   8'h08

// Mode codes and limits
`define SCDD_MODE_OFF       3'h0
`define SCDD_MODE_RSVD      3'h1
`define SCDD_MODE_FINE16    3'h2
`define SCDD_MODE_FINE16_LJ 3'h3
`define SCDD_MODE_FINE192   3'h4
`define SCDD_MODE_FINE192_B 3'h5
`define SCDD_MODE_FULL      3'h6
`define SCDD_FINE16_MAX     8'h10
`define SCDD_FINE_MAX       8'hC0
`define SCDD_SF_MAX         8'h80
`define SCDD_THR_HIGH_RATE  2'h1
`define SCDD_THR_LOW_RATE   2'h3

// Step sizes in femtoseconds: 1.725 ps and 0.25 ps
`define SCDD_FINE_STEP_FS   20'h006BD
`define SCDD_SF_STEP_FS     20'h000FA

// Clock detector window in clk cycles, minimum counts in sensed edges per window
`define SCDD_DET_WIN_LAST   8'h3F
`define SCDD_DET_MIN_HIGH   8'h10
`define SCDD_DET_MIN_LOW    8'h08

`endif

// ### hdl/scdd_clk_detect.sv
`include "scdd_cfg.svh"

module scdd_clk_detect
  import scdd_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       rstn,       // Synchronous reset, active low
  input  wire logic       sclk_tick,  // One pulse per sensed sample clock edge
  input  wire logic [1:0] threshold,  // Detection threshold code
  output logic            locked      // Clock detected and locked
);

  scdd_det_state_t state;
  scdd_det_state_t next_state;
  logic [7:0]      win_cnt;
  logic [7:0]      tick_cnt;

  wire       win_end  = (win_cnt == `SCDD_DET_WIN_LAST);
  // Slow clocks give fewer edges per window, so the bar is lower
  wire [7:0] need     = (threshold == `SCDD_THR_LOW_RATE) ? `SCDD_DET_MIN_LOW
                                                          : `SCDD_DET_MIN_HIGH;
  wire       tick_sat = (tick_cnt == 8'hFF);
  wire       win_ok   = (tick_cnt >= need);

  always_comb
  begin
    next_state = state;
    if (win_end)
    begin
      unique case (state)
        SCDD_DET_NO_CLK:  next_state = win_ok ? SCDD_DET_ACQUIRE : SCDD_DET_NO_CLK;
        SCDD_DET_ACQUIRE: next_state = win_ok ? SCDD_DET_LOCKED : SCDD_DET_NO_CLK;
        SCDD_DET_LOCKED:  next_state = win_ok ? SCDD_DET_LOCKED : SCDD_DET_NO_CLK;
        default:          next_state = SCDD_DET_NO_CLK;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state    <= SCDD_DET_NO_CLK;
      win_cnt  <= 8'h00;
      tick_cnt <= 8'h00;
      locked   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      win_cnt  <= win_end ? 8'h00 : win_cnt + 8'h01;
      tick_cnt <= win_end ? 8'h00 : tick_cnt + {7'h00, sclk_tick & ~tick_sat};
      locked   <= (next_state == SCDD_DET_LOCKED);
    end
  end

endmodule

// ### hdl/scdd_pkg.sv
package scdd_pkg;

  typedef enum logic [2:0] {
    SCDD_DLY_OFF,
    SCDD_DLY_FINE16,
    SCDD_DLY_FINE16_LJ,
    SCDD_DLY_FINE192,
    SCDD_DLY_FULL
  } scdd_dly_mode_t;

  typedef enum logic [1:0] {
    SCDD_DET_NO_CLK,
    SCDD_DET_ACQUIRE,
    SCDD_DET_LOCKED
  } scdd_det_state_t;

endpackage

// ### hdl/scdd_top.sv
// Functional notes
// - Positive skew window: zero to one-and-half clocks
// - Modes 000/010/011: none, fine, low-jitter, 0-16
// - Mode 100 full fine; 001 reserved
// - Mode 101 behaves exactly as 100
// - Mode 110 adds super-fine over 128 steps
// - Super-fine count, 0.25 ps steps, resets zero
// - Fine count, 1.725 ps steps, resets 0xC0
// - Status bit shows detected and locked clock
// - Stabilizer: power before enable, else bypassed
// - Step values act only in enabling mode
// - Negative skew window mirrors positive encoding
`include "scdd_cfg.svh"

module scdd_top
  import scdd_pkg::*;
(
  input  wire logic        clk,                  // System clock, 10 MHz
  input  wire logic        rstn,                 // Synchronous reset, active low
  input  wire logic [11:0] reg_addr,             // Register address
  input  wire logic [7:0]  reg_wdata,            // Register write data
  input  wire logic        reg_wr,               // Write strobe
  input  wire logic        reg_rd,               // Read strobe
  output logic      [7:0]  reg_rdata,            // Read data, cycle after strobe
  input  wire logic        sclk_tick,            // Sensed sample clock edge pulse
  output logic      [1:0]  pos_skew_half,        // Positive skew, half device clocks
  output logic      [1:0]  neg_skew_half,        // Negative skew, half device clocks
  output logic             fine_en,              // Fine delay stage on
  output logic             fine_low_jitter,      // Fine delay low-jitter variant
  output logic             superfine_en,         // Super-fine stage on
  output logic      [7:0]  fine_steps,           // Applied fine step count
  output logic      [7:0]  superfine_steps,      // Applied super-fine step count
  output logic             fine_step_range_err,  // Programmed count beyond mode range
  output logic      [19:0] delay_total_fs,       // Total applied delay in fs
  output logic             delay_update,         // Pulse when applied delay changes
  output logic             dcs1_power_up,        // Stabilizer one powered
  output logic             dcs1_active,          // Stabilizer one in the path
  output logic             clk_locked            // Input clock detected and locked
);

  // Register storage
  logic [3:0]  skew_ctl;
  logic [2:0]  clock_delay_mode;
  logic [7:0]  clock_superfine_delay;
  logic [7:0]  clock_fine_delay;
  logic [7:0]  clock_detect_control;
  logic [7:0]  duty_stabilizer_one_control;
  logic        dcs1_power_held;
  logic        det_locked;

  // Decoded mode and effective stage values
  scdd_dly_mode_t dly_mode;
  logic           next_fine_en;
  logic           next_fine_low_jitter;
  logic           next_superfine_en;
  logic [7:0]     next_fine_steps;
  logic [7:0]     next_superfine_steps;
  logic           next_range_err;
  logic [19:0]    next_delay_total_fs;
  logic [7:0]     next_rdata;

  // Address decode
  wire sel_skew  = (reg_addr == `SCDD_ADDR_SKEW);
  wire sel_mode  = (reg_addr == `SCDD_ADDR_DLY_MODE);
  wire sel_sf    = (reg_addr == `SCDD_ADDR_SF_DLY);
  wire sel_fine  = (reg_addr == `SCDD_ADDR_FINE_DLY);
  wire sel_det   = (reg_addr == `SCDD_ADDR_DET_CTL);
  wire sel_sts   = (reg_addr == `SCDD_ADDR_LOCK_STS);
  wire sel_dcs1  = (reg_addr == `SCDD_ADDR_DCS1_CTL);

  wire wr_skew   = reg_wr & sel_skew;
  wire wr_mode   = reg_wr & sel_mode;
  wire wr_sf     = reg_wr & sel_sf;
  wire wr_fine   = reg_wr & sel_fine;
  wire wr_det    = reg_wr & sel_det;
  wire wr_dcs1   = reg_wr & sel_dcs1;

  // Read-back words; unused upper bits read as zero
  wire [7:0] rd_skew = {4'h0, skew_ctl};
  wire [7:0] rd_mode = {5'h00, clock_delay_mode};
  wire [7:0] rd_sts  = {7'h00, det_locked};

  assign next_rdata = sel_skew ? rd_skew :
                      sel_mode ? rd_mode :
                      sel_sf   ? clock_superfine_delay :
                      sel_fine ? clock_fine_delay :
                      sel_det  ? clock_detect_control :
                      sel_sts  ? rd_sts :
                      sel_dcs1 ? duty_stabilizer_one_control :
                      8'h00;

  // Skew window register, positive and negative halves
  always_ff @(posedge clk)
  begin
    if (!rstn)
      skew_ctl <= `SCDD_RST_SKEW;
    else if (wr_skew)
      skew_ctl <= reg_wdata[3:0];
  end

  // Mode register; reserved bits are not stored
  always_ff @(posedge clk)
  begin
    if (!rstn)
      clock_delay_mode <= `SCDD_RST_DLY_MODE;
    else if (wr_mode)
      clock_delay_mode <= reg_wdata[`SCDD_MODE_MSB:`SCDD_MODE_LSB];
  end

  // Step count registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      clock_superfine_delay <= `SCDD_RST_SF_DLY;
      clock_fine_delay      <= `SCDD_RST_FINE_DLY;
    end
    else
    begin
      if (wr_sf)
        clock_superfine_delay <= reg_wdata;
      if (wr_fine)
        clock_fine_delay <= reg_wdata;
    end
  end

  // Detection threshold; reserved bits stay writable as stored bits
  always_ff @(posedge clk)
  begin
    if (!rstn)
      clock_detect_control <= `SCDD_RST_DET_CTL;
    else if (wr_det)
      clock_detect_control <= reg_wdata;
  end

  // Stabilizer one control
  always_ff @(posedge clk)
  begin
    if (!rstn)
      duty_stabilizer_one_control <= `SCDD_RST_DCS1_CTL;
    else if (wr_dcs1)
      duty_stabilizer_one_control <= reg_wdata;
  end

  // Read port: data stand one cycle only
  always_ff @(posedge clk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // Skew windows, both fields share one encoding
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pos_skew_half <= 2'h0;
      neg_skew_half <= 2'h0;
    end
    else
    begin
      pos_skew_half <= skew_ctl[`SCDD_POS_SKEW_MSB:`SCDD_POS_SKEW_LSB];
      neg_skew_half <= skew_ctl[`SCDD_NEG_SKEW_MSB:`SCDD_NEG_SKEW_LSB];
    end
  end

  // Mode decode; reserved 001 and unlisted 111 fall back to no delay
  always_comb
  begin
    unique case (clock_delay_mode)
      `SCDD_MODE_OFF:       dly_mode = SCDD_DLY_OFF;
      `SCDD_MODE_FINE16:    dly_mode = SCDD_DLY_FINE16;
      `SCDD_MODE_FINE16_LJ: dly_mode = SCDD_DLY_FINE16_LJ;
      `SCDD_MODE_FINE192:   dly_mode = SCDD_DLY_FINE192;
      `SCDD_MODE_FINE192_B: dly_mode = SCDD_DLY_FINE192;
      `SCDD_MODE_FULL:      dly_mode = SCDD_DLY_FULL;
      default:              dly_mode = SCDD_DLY_OFF;
    endcase
  end

  // Stage enables follow the decoded mode
  assign next_fine_en         = (dly_mode != SCDD_DLY_OFF);
  assign next_fine_low_jitter = (dly_mode == SCDD_DLY_FINE16_LJ);
  assign next_superfine_en    = (dly_mode == SCDD_DLY_FULL);

  wire short_range = (dly_mode == SCDD_DLY_FINE16) |
                     (dly_mode == SCDD_DLY_FINE16_LJ);

  // Clamp rather than pass an invalid count to the analog ladder
  wire [7:0] fine_limit = short_range ? `SCDD_FINE16_MAX : `SCDD_FINE_MAX;
  wire       fine_over  = (clock_fine_delay > fine_limit);
  wire       sf_over    = (clock_superfine_delay > `SCDD_SF_MAX);

  wire [7:0] fine_clamped = fine_over ? fine_limit : clock_fine_delay;
  wire [7:0] sf_clamped   = sf_over ? `SCDD_SF_MAX : clock_superfine_delay;

  // Steps are ignored by a stage that the mode leaves off
  assign next_fine_steps      = next_fine_en ? fine_clamped : 8'h00;
  assign next_superfine_steps = next_superfine_en ? sf_clamped : 8'h00;

  assign next_range_err = (next_fine_en & fine_over) |
                          (next_superfine_en & sf_over);

  // Sum of both stages, in femtoseconds to stay integral
  wire [19:0] fine_fs = {12'h000, next_fine_steps} * `SCDD_FINE_STEP_FS;
  wire [19:0] sf_fs   = {12'h000, next_superfine_steps} * `SCDD_SF_STEP_FS;

  assign next_delay_total_fs = fine_fs + sf_fs;

  wire delay_changed = (next_delay_total_fs != delay_total_fs) |
                       (next_fine_en != fine_en) |
                       (next_superfine_en != superfine_en) |
                       (next_fine_low_jitter != fine_low_jitter);

  // Applied delay outputs
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fine_en             <= 1'b0;
      fine_low_jitter     <= 1'b0;
      superfine_en        <= 1'b0;
      fine_steps          <= 8'h00;
      superfine_steps     <= 8'h00;
      fine_step_range_err <= 1'b0;
      delay_total_fs      <= 20'h00000;
    end
    else
    begin
      fine_en             <= next_fine_en;
      fine_low_jitter     <= next_fine_low_jitter;
      superfine_en        <= next_superfine_en;
      fine_steps          <= next_fine_steps;
      superfine_steps     <= next_superfine_steps;
      fine_step_range_err <= next_range_err;
      delay_total_fs      <= next_delay_total_fs;
    end
  end

  // One-cycle notice so the analog side can resettle
  always_ff @(posedge clk)
  begin
    if (!rstn)
      delay_update <= 1'b0;
    else
      delay_update <= delay_changed;
  end

  // Enable is honoured only after power has stood a full cycle,
  // so a single write of both bits still powers up first
  wire dcs1_pwr_bit = duty_stabilizer_one_control[`SCDD_DCS_PWR_BIT];
  wire dcs1_en_bit  = duty_stabilizer_one_control[`SCDD_DCS_EN_BIT];

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      dcs1_power_held <= 1'b0;
      dcs1_power_up   <= 1'b0;
      dcs1_active     <= 1'b0;
    end
    else
    begin
      dcs1_power_held <= dcs1_pwr_bit;
      dcs1_power_up   <= dcs1_pwr_bit;
      dcs1_active     <= dcs1_en_bit & dcs1_pwr_bit & dcs1_power_held;
    end
  end

  // Clock presence detector
  scdd_clk_detect u_detect (
    .clk       (clk),
    .rstn      (rstn),
    .sclk_tick (sclk_tick),
    .threshold (clock_detect_control[`SCDD_THR_MSB:`SCDD_THR_LSB]),
    .locked    (det_locked)
  );

  assign clk_locked = det_locked;

endmodule

// ### verif/sample_clock_delay_detect_bench.sv
module sample_clock_delay_detect_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, run = 1'h0;
  logic        rd_d = 1'h0, fe, se;
  logic [3:0]  gap = 4'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, fs, ss, lim, ef, es, fine_steps, superfine_steps;
  logic [1:0]  pos_skew_half, neg_skew_half;
  logic        fine_en, fine_low_jitter, superfine_en, fine_step_range_err, delay_update;
  logic        dcs1_power_up, dcs1_active, clk_locked, sclk_tick;
  logic [19:0] delay_total_fs;
  logic [31:0] seed = 32'h7, r;
  logic [2:0]  m;
  logic [7:0]  exp_q[$];
  logic [11:0] ra[7] = '{12'h110, 12'h111, 12'h112, 12'h11A, 12'h11B, 12'h11C, 12'h1FF};
  logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'hC0, 8'h09, 8'h00, 8'h08, 8'h00};
  int          n_errors = 0, checked = 0, cyc = 0;

  scdd_top u_scdd_top (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sclk_tick, .pos_skew_half, .neg_skew_half, .fine_en, .fine_low_jitter, .superfine_en,
    .fine_steps, .superfine_steps, .fine_step_range_err, .delay_total_fs, .delay_update,
    .dcs1_power_up, .dcs1_active, .clk_locked);
  scdd_clk_src u_scdd_clk_src (.clk, .run, .gap, .sclk_tick);

  initial forever #50 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic print_verdict();
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'h0;
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic wait_lock(input logic v, input int n);
    for (int i = 0; i < n && clk_locked !== v; i++)
      @(negedge clk);
    chk(clk_locked, v);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    cyc  <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    foreach (ra[k]) rd(ra[k], rv[k]);
    wr(12'h110, 8'hFF);
    rd(12'h110, 8'h07);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      wr(12'h10A, {r[7:4], ~i[1:0], i[1:0]});
      settle();
      chk(pos_skew_half, i[1:0]);
      chk(neg_skew_half, 2'(~i[1:0]));
      rd(12'h10A, {4'h0, ~i[1:0], i[1:0]});
    end
    // First eight passes put fine one over the 16 limit and super-fine on its limit, later passes are random
    for (int i = 0; i < 24; i++)
    begin
      r  = xs();
      m  = i[2:0];
      fs = i < 8 ? 8'h11 : r[7:0];
      ss = i < 8 ? 8'h80 : r[15:8];
      wr(12'h112, fs);
      wr(12'h111, ss);
      wr(12'h110, {5'h00, m});
      settle();
      fe  = m inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
      se  = m == 3'h6;
      lim = m < 3'h4 ? 8'h10 : 8'hC0;
      ef  = fe ? (fs > lim ? lim : fs) : 8'h00;
      es  = se ? (ss > 8'h80 ? 8'h80 : ss) : 8'h00;
      chk(fine_en, fe);
      chk(fine_low_jitter, m == 3'h3);
      chk(superfine_en, se);
      chk(fine_steps, ef);
      chk(superfine_steps, es);
      chk(fine_step_range_err, (fe && fs > lim) || (se && ss > 8'h80));
      chk(delay_total_fs, ef * 20'h006BD + es * 20'h000FA);
      rd(12'h111, ss);
    end
    @(posedge clk);
    run <= 1'h1;
    wait_lock(1'h1, 200);
    wr(12'h11B, 8'h00);
    rd(12'h11B, 8'h01);
    @(posedge clk);
    run <= 1'h0;
    wait_lock(1'h0, 200);
    @(posedge clk);
    gap <= 4'h5;
    run <= 1'h1;
    repeat (300) @(negedge clk);
    chk(clk_locked, 1'h0);
    wr(12'h11A, 8'h19);
    rd(12'h11A, 8'h19);
    wait_lock(1'h1, 300);
    wr(12'h11C, 8'h0A);
    settle();
    chk(dcs1_active, 1'h0);
    wr(12'h11C, 8'h09);
    wr(12'h11C, 8'h0B);
    settle();
    chk(dcs1_power_up, 1'h1);
    chk(dcs1_active, 1'h1);
    rd(12'h11C, 8'h0B);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule

// ### verif/scdd_clk_src.sv
module scdd_clk_src (
  input  wire logic       clk,              // Bench clock
  input  wire logic       run,              // Source toggling
  input  wire logic [3:0] gap,              // Idle cycles between edges
  output logic            sclk_tick = 1'h0  // Sensed edge pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  // Silent when stopped, no stale tick left behind
  always @(posedge clk)
  begin
    cnt       <= (!run || cnt >= gap) ? 4'h0 : cnt + 4'h1;
    sclk_tick <= run && cnt >= gap;
  end
endmodule

// ### verif/scdd_monitor.sv
module scdd_monitor (
  input wire logic        clk,             // Clock
  input wire logic        rstn,            // Reset
  input wire logic [11:0] reg_addr,        // Address
  input wire logic        reg_rd,          // Read strobe
  input wire logic [7:0]  reg_rdata,       // Read data
  input wire logic        fine_en,         // Fine on
  input wire logic        fine_low_jitter, // Low jitter
  input wire logic        superfine_en,    // Super-fine on
  input wire logic [7:0]  fine_steps,      // Fine count
  input wire logic [7:0]  superfine_steps, // Super-fine count
  input wire logic [19:0] delay_total_fs,  // Total delay
  input wire logic        delay_update,    // Change pulse
  input wire logic        dcs1_power_up,   // Powered
  input wire logic        dcs1_active,     // In path
  input wire logic        clk_locked       // Locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_fine_off;
    !fine_en |-> fine_steps == 8'h00;
  endproperty
  a_fine_off: assert property (p_fine_off) else $error("fine count while off");
  property p_sf_off;
    !superfine_en |-> superfine_steps == 8'h00;
  endproperty
  a_sf_off: assert property (p_sf_off) else $error("super-fine count while off");
  property p_sf_mode;
    superfine_en |-> fine_en && !fine_low_jitter;
  endproperty
  a_sf_mode: assert property (p_sf_mode) else $error("super-fine without fine");
  property p_lj_range;
    fine_low_jitter |-> fine_steps <= 8'h10;
  endproperty
  a_lj_range: assert property (p_lj_range) else $error("low jitter over 16");
  property p_range;
    fine_steps <= 8'hC0 && superfine_steps <= 8'h80;
  endproperty
  a_range: assert property (p_range) else $error("count over range");
  property p_total;
    delay_total_fs == fine_steps * 20'h006BD + superfine_steps * 20'h000FA;
  endproperty
  a_total: assert property (p_total) else $error("total delay wrong");
  property p_upd;
    $changed(delay_total_fs) |-> delay_update;
  endproperty
  a_upd: assert property (p_upd) else $error("no update pulse");
  property p_dcs;
    $rose(dcs1_active) |-> $past(dcs1_power_up) && dcs1_power_up;
  endproperty
  a_dcs: assert property (p_dcs) else $error("enabled before power");
  property p_lock_rd;
    reg_rd && reg_addr == 12'h11B |=> reg_rdata == {7'h00, $past(clk_locked)};
  endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("status read wrong");
  c_sf: cover property (superfine_en);
  c_dcs: cover property ($rose(dcs1_active));
  c_lock: cover property ($rose(clk_locked));
endmodule

bind scdd_top scdd_monitor u_scdd_monitor (
  .clk, .rstn, .reg_addr, .reg_rd, .reg_rdata, .fine_en, .fine_low_jitter,
  .superfine_en, .fine_steps, .superfine_steps, .delay_total_fs, .delay_update,
  .dcs1_power_up, .dcs1_active, .clk_locked
);
